// File: logic/buffer_admission_map.svh
/*
  Constants of the buffer admission block: register indices, field
  positions, reset values and fixed counts. Included by bare name.
*/
`ifndef BUFFER_ADMISSION_MAP_SVH
`define BUFFER_ADMISSION_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define BA_ADDR_W 16
`define BA_IDX_CFG 14'h1c00
`define BA_IDX_DROP 14'h1c01
`define BA_IDX_PAUSE 14'h1c02
`define BA_IDX_RESUME 14'h1c03
`define BA_IDX_CNT0 14'h1c05
`define BA_IDX_STATUS 14'h1c0f

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define BA_CFG_TEST 6
`define BA_CFG_FIXED 5
`define BA_CFG_PACE_HI 4
`define BA_CFG_PACE_LO 2
`define BA_CFG_YELLOW 1
`define BA_CFG_RED 0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define BA_CFG_RST 7'h00
`define BA_DROP_RST 16'h4964
`define BA_PAUSE_RST 16'h213c
`define BA_RESUME_RST 16'h0307
`define BA_CNT_TEST 32'h7ffffffc
`define BA_CNT_MAX 32'hffffffff
`define BA_ACTIVE_BUFS 10'h024
`define BA_BUF_BYTES 128
`define BA_WRR_W0 4'h1
`define BA_WRR_W1 4'h2
`define BA_WRR_W2 4'h3
`define BA_WRR_W3 4'h4

`endif

// File: logic/buffer_admission_pkg.sv
/*
  Types of the buffer admission block.
  Assumes nothing of its surroundings.
*/
package buffer_admission_pkg;
  typedef enum logic {FLOW_RUN = 1'b0, FLOW_HELD = 1'b1} flow_state_type;
  typedef enum logic [1:0] {
    COLOR_GREEN = 2'h0,
    COLOR_YELLOW = 2'h1,
    COLOR_RED = 2'h2
  } color_type;
  // Buffer counts, one buffer is 128 bytes
  typedef logic [9:0] usage_type;
  typedef logic [7:0] level_type;
endpackage

// File: logic/queue_service_arbiter.sv
/*
  Output queue arbiter of one switch port: fixed priority or weighted
  round robin over four queues.
  Assumes q_req and q_take come from logic on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
`include "buffer_admission_map.svh"

module queue_service_arbiter (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Mode
  input wire logic fixed_prio,
  // Queues
  input wire logic [3:0] q_req,
  input wire logic q_take,
  output logic [3:0] q_grant
);
  import buffer_admission_pkg::*;

  logic [3:0] grant_r, grant_nxt;
  logic [1:0] ptr_r, ptr_nxt;
  logic [3:0] credit_r, credit_nxt;

  function automatic logic [3:0] weight(input logic [1:0] q);
    case (q)
      2'h0: weight = `BA_WRR_W0;
      2'h1: weight = `BA_WRR_W1;
      2'h2: weight = `BA_WRR_W2;
      default: weight = `BA_WRR_W3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Queue selection
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] n;
    n = ptr_r;
    grant_nxt = 4'h0;
    ptr_nxt = ptr_r;
    credit_nxt = credit_r;
    if (q_take && (|q_req)) begin
      if (fixed_prio) begin
        for (int k = 0; k < 4; k++) begin
          if (q_req[k]) begin
            n = 2'(k);
          end
        end
        grant_nxt = 4'h1 << n;
      end else if (q_req[ptr_r] && (credit_r != 4'h0)) begin
        grant_nxt = 4'h1 << ptr_r;
        credit_nxt = credit_r - 4'h1;
      end else begin
        for (int k = 4; k > 0; k--) begin
          if (q_req[2'(ptr_r + 2'(k))]) begin
            n = 2'(ptr_r + 2'(k));
          end
        end
        grant_nxt = 4'h1 << n;
        ptr_nxt = n;
        credit_nxt = weight(n) - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      grant_r <= 4'h0;
      ptr_r <= 2'h0;
      credit_r <= 4'h0;
    end else begin
      grant_r <= grant_nxt;
      ptr_r <= ptr_nxt;
      credit_r <= credit_nxt;
    end
  end

  assign q_grant = grant_r;

  a_fixed_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q_take && fixed_prio && q_req[3] |=> q_grant == 4'h8)
    else $error("fixed priority did not serve top queue");

endmodule
`default_nettype wire

// File: logic/buffer_admission_ctl.sv
/*
  Buffer admission and flow control of a three port switch: threshold
  registers, per port drop decisions, pause and resume requests, drop
  counters and egress queue servicing, with an Avalon-MM slave.
  Assumes buffer usage, requests and colors come from logic on clk_sys.
*/
// Notes on behaviour
// - Counter test set: a read loads the drop counter with 7FFF_FFFC instead.
// - Queue servicing bit set gives fixed priority; clear gives weighted round robin.
// - Config bits 4,3,2 enable egress pacing on ports 2,1,0.
// - Yellow drop set: yellow packets go to random discard.
// - Red drop set: red packets are discarded.
// - A port with 36 buffers in use is active; active count picks levels.
// - All levels count buffers of 128 bytes.
// - Two or three active ports: drop at low drop level, reset 49h.
// - One active port: drop at high drop level, reset 64h.
// - Pause at pause level: low 21h with two or more, high 3Ch otherwise.
// - Resume at resume level: low 03h with two or more, high 07h otherwise.
// - Per port drop counters count dropped packets and clear when read.
`timescale 1ns/10ps
`default_nettype none
`include "buffer_admission_map.svh"

module buffer_admission_ctl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Avalon-MM register slave
  input wire logic [`BA_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Ingress admission
  input wire buffer_admission_pkg::usage_type buf_used [3],
  input wire logic [2:0] alloc_req,
  input wire buffer_admission_pkg::color_type pkt_color [3],
  input wire logic [2:0] rnd_discard,
  output logic [2:0] alloc_grant,
  output logic [2:0] alloc_drop,
  // Flow control
  output logic [2:0] pause_hold,
  output logic [2:0] pause_send,
  output logic [2:0] resume_send,
  // Egress
  output logic [2:0] pace_en,
  input wire logic [3:0] q_req [3],
  input wire logic [2:0] q_take,
  output logic [3:0] q_grant [3]
);
  import buffer_admission_pkg::*;

  logic [6:0] cfg_r, cfg_nxt;
  logic [15:0] drop_lvl_r, drop_lvl_nxt;
  logic [15:0] pause_lvl_r, pause_lvl_nxt;
  logic [15:0] resume_lvl_r, resume_lvl_nxt;
  logic [31:0] readdata_r, readdata_nxt;
  logic waitreq_r, waitreq_nxt;
  logic [31:0] drop_cnt_r [3];
  logic [31:0] drop_cnt_nxt [3];
  logic [2:0] grant_r, grant_nxt;
  logic [2:0] drop_r, drop_nxt;
  flow_state_type flow_r [3];
  flow_state_type flow_nxt [3];
  logic [2:0] pause_r, pause_nxt;
  logic [2:0] resume_r, resume_nxt;
  logic acc_ack;
  logic [2:0] active;
  logic many;
  level_type drop_lim [3];
  level_type pause_lim [3];
  level_type resume_lim [3];
  logic [2:0] drop_cond;
  logic [2:0] drop_evt;

  function automatic logic hit(input logic [`BA_ADDR_W-1:0] addr, input logic [13:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction

  function automatic level_type pick(input logic [15:0] lv, input logic low);
    pick = low ? lv[15:8] : lv[7:0];
  endfunction

  function automatic logic at_or_above(input usage_type used, input level_type lim);
    at_or_above = (used >= {2'b00, lim});
  endfunction

  // ----------------------------------------------------------------
  // Level selection
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      active[i] = (buf_used[i] >= `BA_ACTIVE_BUFS);
    end
    many = (active[0] & active[1]) | (active[0] & active[2]) | (active[1] & active[2]);
    for (int i = 0; i < 3; i++) begin
      // Limits are in 128-byte buffers, compared against buffer counts
      drop_lim[i] = pick(drop_lvl_r, many);
      pause_lim[i] = pick(pause_lvl_r, many);
      resume_lim[i] = pick(resume_lvl_r, many);
      drop_cond[i] = at_or_above(buf_used[i], drop_lim[i])
        | ((pkt_color[i] == COLOR_RED) & cfg_r[`BA_CFG_RED])
        | ((pkt_color[i] == COLOR_YELLOW) & cfg_r[`BA_CFG_YELLOW] & rnd_discard[i]);
    end
    drop_evt = alloc_req & drop_cond;
  end

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  assign acc_ack = (avs_read | avs_write) & ~waitreq_r;

  always_comb begin
    waitreq_nxt = ~((avs_read | avs_write) & waitreq_r);
    cfg_nxt = cfg_r;
    drop_lvl_nxt = drop_lvl_r;
    pause_lvl_nxt = pause_lvl_r;
    resume_lvl_nxt = resume_lvl_r;
    readdata_nxt = 32'h0;
    if (acc_ack && avs_write) begin
      if (hit(avs_address, `BA_IDX_CFG)) begin
        cfg_nxt = avs_writedata[6:0];
      end
      if (hit(avs_address, `BA_IDX_DROP)) begin
        drop_lvl_nxt = avs_writedata[15:0];
      end
      if (hit(avs_address, `BA_IDX_PAUSE)) begin
        pause_lvl_nxt = avs_writedata[15:0];
      end
      if (hit(avs_address, `BA_IDX_RESUME)) begin
        resume_lvl_nxt = avs_writedata[15:0];
      end
    end
    if (avs_read && waitreq_r) begin
      if (hit(avs_address, `BA_IDX_CFG)) begin
        readdata_nxt = {25'h0, cfg_r};
      end
      if (hit(avs_address, `BA_IDX_DROP)) begin
        readdata_nxt = {16'h0, drop_lvl_r};
      end
      if (hit(avs_address, `BA_IDX_PAUSE)) begin
        readdata_nxt = {16'h0, pause_lvl_r};
      end
      if (hit(avs_address, `BA_IDX_RESUME)) begin
        readdata_nxt = {16'h0, resume_lvl_r};
      end
      for (int i = 0; i < 3; i++) begin
        if (hit(avs_address, `BA_IDX_CNT0 + 14'(i))) begin
          readdata_nxt = drop_cnt_r[i];
        end
      end
      if (hit(avs_address, `BA_IDX_STATUS)) begin
        readdata_nxt = {26'h0, pause_r | {flow_r[2] == FLOW_HELD, flow_r[1] == FLOW_HELD,
          flow_r[0] == FLOW_HELD}, active};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      waitreq_r <= 1'b1;
      readdata_r <= 32'h0;
      cfg_r <= `BA_CFG_RST;
      drop_lvl_r <= `BA_DROP_RST;
      pause_lvl_r <= `BA_PAUSE_RST;
      resume_lvl_r <= `BA_RESUME_RST;
    end else begin
      waitreq_r <= waitreq_nxt;
      readdata_r <= readdata_nxt;
      cfg_r <= cfg_nxt;
      drop_lvl_r <= drop_lvl_nxt;
      pause_lvl_r <= pause_lvl_nxt;
      resume_lvl_r <= resume_lvl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Drop counters
  // ----------------------------------------------------------------
  // Clearing subtracts the value just returned, so drops that land
  // between the snapshot and the clear are kept.
  always_comb begin
    logic [31:0] base;
    base = 32'h0;
    for (int i = 0; i < 3; i++) begin
      base = drop_cnt_r[i];
      if (acc_ack && avs_read && hit(avs_address, `BA_IDX_CNT0 + 14'(i))) begin
        if (cfg_r[`BA_CFG_TEST]) begin
          base = `BA_CNT_TEST;
        end else begin
          base = drop_cnt_r[i] - readdata_r;
        end
      end
      if (drop_evt[i] && (base != `BA_CNT_MAX)) begin
        base = base + 32'h1;
      end
      drop_cnt_nxt[i] = base;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        drop_cnt_r[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        drop_cnt_r[i] <= drop_cnt_nxt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Admission and flow control
  // ----------------------------------------------------------------
  always_comb begin
    grant_nxt = alloc_req & ~drop_cond;
    drop_nxt = drop_evt;
    pause_nxt = 3'h0;
    resume_nxt = 3'h0;
    for (int i = 0; i < 3; i++) begin
      flow_nxt[i] = flow_r[i];
      case (flow_r[i])
        FLOW_RUN: begin
          if (at_or_above(buf_used[i], pause_lim[i])) begin
            flow_nxt[i] = FLOW_HELD;
            pause_nxt[i] = 1'b1;
          end
        end
        FLOW_HELD: begin
          if (buf_used[i] <= {2'b00, resume_lim[i]}) begin
            flow_nxt[i] = FLOW_RUN;
            resume_nxt[i] = 1'b1;
          end
        end
        default: begin
          flow_nxt[i] = FLOW_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      grant_r <= 3'h0;
      drop_r <= 3'h0;
      pause_r <= 3'h0;
      resume_r <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        flow_r[i] <= FLOW_RUN;
      end
    end else begin
      grant_r <= grant_nxt;
      drop_r <= drop_nxt;
      pause_r <= pause_nxt;
      resume_r <= resume_nxt;
      for (int i = 0; i < 3; i++) begin
        flow_r[i] <= flow_nxt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Egress queue servicing
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : gen_port
    queue_service_arbiter u_arb (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .fixed_prio(cfg_r[`BA_CFG_FIXED]),
      .q_req(q_req[g]),
      .q_take(q_take[g]),
      .q_grant(q_grant[g])
    );
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata = readdata_r;
  assign avs_waitrequest = waitreq_r;
  assign alloc_grant = grant_r;
  assign alloc_drop = drop_r;
  assign pause_send = pause_r;
  assign resume_send = resume_r;
  assign pace_en = cfg_r[`BA_CFG_PACE_HI:`BA_CFG_PACE_LO];
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pause_hold[i] = (flow_r[i] == FLOW_HELD);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_test_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc_ack && avs_read && cfg_r[`BA_CFG_TEST] && hit(avs_address, `BA_IDX_CNT0)
      && !drop_evt[0] |=> drop_cnt_r[0] == `BA_CNT_TEST)
    else $error("counter test read did not load test value");

  a_clear_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc_ack && avs_read && !cfg_r[`BA_CFG_TEST] && hit(avs_address, `BA_IDX_CNT0)
      && !drop_evt[0] && !$past(drop_evt[0]) |=> drop_cnt_r[0] == 32'h0)
    else $error("drop counter not cleared by read");

  a_pace_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc_ack && avs_write && hit(avs_address, `BA_IDX_CFG)
      |=> pace_en == $past(avs_writedata[4:2]))
    else $error("pacing enables do not follow config write");

  a_red_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    alloc_req[0] && pkt_color[0] == COLOR_RED && cfg_r[`BA_CFG_RED]
      |=> alloc_drop[0] && !alloc_grant[0])
    else $error("red packet admitted");

  a_yellow_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
    alloc_req[0] && pkt_color[0] == COLOR_YELLOW && !cfg_r[`BA_CFG_YELLOW]
      && buf_used[0] < {2'b00, drop_lvl_r[15:8]} && buf_used[0] < {2'b00, drop_lvl_r[7:0]}
      |=> alloc_grant[0])
    else $error("yellow packet dropped with yellow drop off");

  a_low_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    alloc_req[0] && (active[1] || active[2]) && buf_used[0] >= `BA_ACTIVE_BUFS
      && buf_used[0] >= {2'b00, drop_lvl_r[15:8]} |=> alloc_drop[0])
    else $error("low drop level not enforced");

  a_high_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    alloc_req[0] && !active[1] && !active[2] && buf_used[0] < {2'b00, drop_lvl_r[7:0]}
      && pkt_color[0] == COLOR_GREEN |=> alloc_grant[0])
    else $error("high drop level not used with one port active");

  a_pause_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pause_hold[0] && buf_used[0] >= {2'b00, pause_lim[0]}
      |=> pause_send[0] && pause_hold[0] ##1 !pause_send[0])
    else $error("pause not sent at pause level");

  a_hold_resume: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pause_hold[0] && buf_used[0] > {2'b00, resume_lim[0]}
      |=> pause_hold[0] && !resume_send[0])
    else $error("resume sent above resume level");

  a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not exactly one cycle");

endmodule
`default_nettype wire

// File: sim/port_side_model.sv
/*
  Switch port side of the buffer admission block: buffer usage,
  allocation requests with color and discard verdict, queue requests.
  Assumes the bench calls its tasks and runs it on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none

module port_side_model (
  // Clock
  input wire logic clk_sys,
  // Admission
  output var buffer_admission_pkg::usage_type buf_used [3],
  output var logic [2:0] alloc_req,
  output var buffer_admission_pkg::color_type pkt_color [3],
  output var logic [2:0] rnd_discard,
  input wire logic [2:0] alloc_grant,
  input wire logic [2:0] alloc_drop,
  // Egress
  output var logic [3:0] q_req [3],
  output var logic [2:0] q_take,
  input wire logic [3:0] q_grant [3]
);
  import buffer_admission_pkg::*;

  initial begin
    buf_used = '{10'h000, 10'h000, 10'h000};
    pkt_color = '{COLOR_GREEN, COLOR_GREEN, COLOR_GREEN};
    q_req = '{4'h0, 4'h0, 4'h0};
    alloc_req = 3'h0;
    rnd_discard = 3'h0;
    q_take = 3'h0;
  end

  task automatic set_used(input int p, input usage_type u);
    @(posedge clk_sys);
    buf_used[p] <= u;
  endtask

  // Color and verdict are only meaningful with the request, so they flip after it
  task automatic ask(input int p, input color_type c, input logic rnd, output logic [1:0] res);
    @(posedge clk_sys);
    alloc_req[p] <= 1'b1;
    pkt_color[p] <= c;
    rnd_discard[p] <= rnd;
    @(posedge clk_sys);
    alloc_req[p] <= 1'b0;
    pkt_color[p] <= color_type'(~c);
    rnd_discard[p] <= ~rnd;
    #1 res = {alloc_grant[p], alloc_drop[p]};
  endtask

  task automatic take(input int p, input logic [3:0] req, output logic [3:0] g);
    @(posedge clk_sys);
    q_req[p] <= req;
    q_take[p] <= 1'b1;
    @(posedge clk_sys);
    q_take[p] <= 1'b0;
    #1 g = q_grant[p];
  endtask
endmodule

`default_nettype wire

// File: sim/buffer_admission_ctl_tb.sv
/*
  Self-checking bench of the buffer admission block over its register bus.
  Assumes the port side model drives the switch port inputs.
*/
`timescale 1ns/10ps
`default_nettype none

module buffer_admission_ctl_tb;
  import buffer_admission_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  usage_type buf_used [3];
  color_type pkt_color [3];
  logic [2:0] alloc_req, rnd_discard, alloc_grant, alloc_drop;
  logic [2:0] pause_hold, pause_send, resume_send, pace_en, q_take;
  logic [3:0] q_req [3];
  logic [3:0] q_grant [3];
  int n_fail = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic [1:0] res;
  logic [3:0] g;
  logic [3:0] wrr_exp [7] = '{4'h2, 4'h2, 4'h4, 4'h4, 4'h4, 4'h8, 4'h8};
  localparam logic [1:0] GR = 2'b10;
  localparam logic [1:0] DR = 2'b01;

  always #5 clk_sys = ~clk_sys;

  buffer_admission_ctl buffer_admission_ctl_i (.clk_sys, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .buf_used, .alloc_req,
    .pkt_color, .rnd_discard, .alloc_grant, .alloc_drop, .pause_hold, .pause_send,
    .resume_send, .pace_en, .q_req, .q_take, .q_grant);

  port_side_model port_side_model_i (.clk_sys, .buf_used, .alloc_req, .pkt_color,
    .rnd_discard, .alloc_grant, .alloc_drop, .q_req, .q_take, .q_grant);

  // ----------------------------------------------------------------
  // Checks and bus access
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    chk(i < 20, 1'b1, "bus answer");
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input string msg);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, msg);
  endtask

  task automatic adm(input int p, input usage_type u, input color_type c, input logic rnd,
                     input logic [1:0] exp);
    port_side_model_i.set_used(p, u);
    port_side_model_i.ask(p, c, rnd, res);
    chk(res, exp, "admission");
  endtask

  task automatic flow(input int p, input usage_type u, input logic ps, input logic rs,
                      input logic hold);
    logic sp, sr;
    sp = 1'b0;
    sr = 1'b0;
    port_side_model_i.set_used(p, u);
    repeat (6) begin
      @(posedge clk_sys);
      sp |= pause_send[p];
      sr |= resume_send[p];
    end
    chk({sp, sr, pause_hold[p]}, {ps, rs, hold}, "flow control");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(16'h7000, 32'h0, "config reset");
    rdc(16'h7004, 32'h4964, "drop reset");
    rdc(16'h7008, 32'h213c, "pause reset");
    rdc(16'h700c, 32'h0307, "resume reset");
    rdc(16'h7014, 32'h0, "counter reset");
    bus(1'b1, 16'h7020, 32'hffffffff);
    rdc(16'h7020, 32'h0, "unmapped");
    // Weighted round robin from reset, then fixed priority
    for (int k = 0; k < 7; k++) begin
      port_side_model_i.take(0, 4'hf, g);
      chk(g, wrr_exp[k], "round robin");
    end
    port_side_model_i.take(0, 4'h0, g);
    chk(g, 4'h0, "no queue");
    bus(1'b1, 16'h7000, 32'h20);
    port_side_model_i.take(0, 4'h9, g);
    chk(g, 4'h8, "fixed");
    port_side_model_i.take(0, 4'h6, g);
    chk(g, 4'h4, "fixed");
    // Pacing enables, port 2 then port 0
    bus(1'b1, 16'h7000, 32'h10);
    repeat (2) @(posedge clk_sys);
    #1 chk(pace_en, 3'h4, "pacing");
    bus(1'b1, 16'h7000, 32'h04);
    repeat (2) @(posedge clk_sys);
    #1 chk(pace_en, 3'h1, "pacing");
    rdc(16'h7000, 32'h04, "config readback");
    // Drop levels by active port count
    adm(0, 10'h063, COLOR_GREEN, 1'b0, GR);
    adm(0, 10'h064, COLOR_GREEN, 1'b0, DR);
    port_side_model_i.set_used(1, 10'h024);
    adm(0, 10'h049, COLOR_GREEN, 1'b0, DR);
    adm(0, 10'h048, COLOR_GREEN, 1'b0, GR);
    port_side_model_i.set_used(1, 10'h023);
    adm(0, 10'h049, COLOR_GREEN, 1'b0, GR);
    bus(1'b1, 16'h7004, 32'h4940);
    adm(0, 10'h049, COLOR_GREEN, 1'b0, DR);
    // Colors on port 2
    bus(1'b1, 16'h7000, 32'h01);
    adm(2, 10'h000, COLOR_RED, 1'b0, DR);
    adm(2, 10'h000, COLOR_YELLOW, 1'b1, GR);
    bus(1'b1, 16'h7000, 32'h02);
    adm(2, 10'h000, COLOR_YELLOW, 1'b1, DR);
    adm(2, 10'h000, COLOR_YELLOW, 1'b0, GR);
    adm(2, 10'h000, COLOR_RED, 1'b1, GR);
    // Drop counters and counter test mode
    rdc(16'h7014, 32'h3, "port 0 drops");
    rdc(16'h7014, 32'h0, "read clear");
    rdc(16'h701c, 32'h2, "port 2 drops");
    bus(1'b1, 16'h7000, 32'h40);
    rdc(16'h7018, 32'h0, "test read");
    rdc(16'h7018, 32'h7ffffffc, "test load");
    bus(1'b1, 16'h7000, 32'h00);
    // Pause and resume with hysteresis
    port_side_model_i.set_used(1, 10'h000);
    flow(0, 10'h000, 1'b0, 1'b1, 1'b0);
    flow(0, 10'h03b, 1'b0, 1'b0, 1'b0);
    flow(0, 10'h03c, 1'b1, 1'b0, 1'b1);
    rdc(16'h703c, 32'h09, "status");
    flow(0, 10'h008, 1'b0, 1'b0, 1'b1);
    flow(0, 10'h007, 1'b0, 1'b1, 1'b0);
    port_side_model_i.set_used(1, 10'h024);
    port_side_model_i.set_used(2, 10'h024);
    flow(0, 10'h021, 1'b1, 1'b0, 1'b1);
    flow(0, 10'h004, 1'b0, 1'b0, 1'b1);
    flow(0, 10'h003, 1'b0, 1'b1, 1'b0);
    summarize();
  end
endmodule

`default_nettype wire
